/* include/wdsc_pkg.sv */
// Package of constants for the watchdog safety control block
package wdsc_pkg;
    // ==========================================================
    // Control and cause byte field positions
    localparam int PRESCALE_LO = 0;
    localparam int PRESCALE_W = 4;
    localparam int ENABLE_BIT = 3;
    localparam int UNLOCK_BIT = 4;
    localparam int IRQ_EN_BIT = 6;
    localparam int RSTFLAG_BIT = 3;
    // ==========================================================
    // Reset values and timing
    localparam logic [3:0] PRESCALE_RST = 4'h0;
    localparam int UNLOCK_WINDOW_CYC = 4;
    localparam logic [2:0] UNLOCK_CNT_W3 = 3'h4;
    localparam int BASE_TICKS = 2048;
    // ==========================================================
    // Timer mode
    typedef enum logic [3:0] {
        WDSC_STOPPED = 4'h1,
        WDSC_IRQ = 4'h2,
        WDSC_RESET = 4'h4,
        WDSC_BOTH = 4'h8
    } wdsc_mode_t;
endpackage : wdsc_pkg

/* hdl/wdsc_timer.sv */
// Watchdog time-out counter with prescale selection
`timescale 1ns/1ps
module wdsc_timer #(
    parameter int BASE = 2048,
    parameter int CW = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic kick_in,
    input wire logic [3:0] prescale_in,
    output logic timeout_out
);
    // ==========================================================
    // Counter
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] limit;
    logic to_nxt;
    logic timeout_r;

    // Limit doubles per prescale step, capped at step 9
    always_comb begin
        limit = CW'(BASE) << ((prescale_in > 4'h9) ? 4'h9 : prescale_in);
        cnt_nxt = cnt_r;
        to_nxt = 1'b0;
        if (!run_in || kick_in) begin
            cnt_nxt = '0;
        end else if (cnt_r >= limit - CW'(1)) begin
            cnt_nxt = '0;
            to_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            timeout_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            timeout_r <= to_nxt;
        end
    end

    assign timeout_out = timeout_r;
endmodule : wdsc_timer

/* hdl/wdsc_top.sv */
// Watchdog control register, safety levels and time-out actions
// Summary of operation
// - Time-out may raise an interrupt instead of resetting the device.
// - Fuse picks level 1 (starts off) or level 2 (starts on, timed changes).
// - Level 1: writing enable one turns the watchdog on freely.
// - Unlock bit self-clears four cycles after being written one.
// - Writing enable zero is ignored unless unlock reads one.
// - Prescale changes accepted only while unlock is set, or at level 1 while the watchdog is off.
// - Level 2: watchdog always enabled, enable reads one.
// - Level 2: even a correct unlock sequence cannot disable it.
// - Level 1: reset flag set forces enable to one.
// - Enable and irq-enable select stopped, interrupt, reset or both.
// - Combined mode: second time-out resets unless irq-enable set again.
`timescale 1ns/1ps
module wdsc_top #(
    parameter int BASE_TICKS = wdsc_pkg::BASE_TICKS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic safety_level_fuse_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic kick_in,
    input wire logic cause_wr_in,
    input wire logic [7:0] cause_wdata_in,
    input wire logic dog_reset_flag_in,
    output logic [7:0] ctrl_rdata_out,
    output logic dog_reset_flag_out,
    output logic dog_irq_out,
    output logic dog_reset_out,
    output logic [3:0] mode_out
);
    // ==========================================================
    // Fuse and reset-flag sampling
    logic fuse_s1_r;
    logic fuse_s2_r;
    logic level2;
    logic flag_r;
    logic flag_nxt;

    // Synchroniser runs through reset so the level is settled at release
    always_ff @(posedge clk_in) begin
        fuse_s1_r <= safety_level_fuse_in;
        fuse_s2_r <= fuse_s1_r;
    end

    // Fuse taken straight from the pin while in reset so level 2 starts on
    assign level2 = rst_in ? safety_level_fuse_in : fuse_s2_r;

    // ==========================================================
    // Control register state
    logic en_r;
    logic en_nxt;
    logic ie_r;
    logic ie_nxt;
    logic [3:0] ps_r;
    logic [3:0] ps_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic [2:0] ucnt_r;
    logic [2:0] ucnt_nxt;
    logic irq_r;
    logic irq_nxt;
    logic rst_out_r;
    logic rst_out_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic timeout;
    logic en_eff;
    logic wr_en;
    logic wr_unlock;
    logic wr_ie;
    logic [3:0] wr_ps;
    wdsc_pkg::wdsc_mode_t mode_r;
    wdsc_pkg::wdsc_mode_t mode_nxt;

    assign wr_en = ctrl_wdata_in[wdsc_pkg::ENABLE_BIT];
    assign wr_unlock = ctrl_wdata_in[wdsc_pkg::UNLOCK_BIT];
    assign wr_ie = ctrl_wdata_in[wdsc_pkg::IRQ_EN_BIT];
    // Prescale field: bits 2:0 plus bit 5 as the high bit
    assign wr_ps = {ctrl_wdata_in[5], ctrl_wdata_in[2:0]};

    // Effective enable with level 2 and reset-flag overrides
    assign en_eff = en_r || level2 || (!level2 && flag_r);

    // Reset-cause flag: hardware set wins over software clear
    always_comb begin
        flag_nxt = flag_r;
        if (cause_wr_in && !cause_wdata_in[wdsc_pkg::RSTFLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (dog_reset_flag_in || rst_out_r) begin
            flag_nxt = 1'b1;
        end
    end

    // Unlock window, enable, prescale and irq-enable updates
    always_comb begin
        en_nxt = en_r;
        ie_nxt = ie_r;
        ps_nxt = ps_r;
        unlock_nxt = unlock_r;
        ucnt_nxt = ucnt_r;
        // Window runs its four cycles; rewriting unlock one does not extend it, a write with unlock zero ends it
        if (unlock_r) begin
            if (ucnt_r == wdsc_pkg::UNLOCK_CNT_W3 - 3'h1) begin
                unlock_nxt = 1'b0;
                ucnt_nxt = 3'h0;
            end else begin
                ucnt_nxt = ucnt_r + 3'h1;
            end
        end
        if (ctrl_wr_in) begin
            ie_nxt = wr_ie;
            if (wr_unlock && wr_en && !unlock_r) begin
                unlock_nxt = 1'b1;
                ucnt_nxt = 3'h0;
                en_nxt = 1'b1;
            end else if (!wr_unlock) begin
                if (wr_en) begin
                    en_nxt = 1'b1;
                end else if (unlock_r && !level2 && !flag_r) begin
                    en_nxt = 1'b0;
                end
            end
            if (unlock_r || (!level2 && !en_eff)) begin
                ps_nxt = wr_ps;
            end
            if (unlock_r && !wr_unlock) begin
                unlock_nxt = 1'b0;
                ucnt_nxt = 3'h0;
            end
        end
        // Interrupt fired in combined mode: next time-out resets
        if (timeout && mode_r == wdsc_pkg::WDSC_BOTH) begin
            ie_nxt = 1'b0;
        end
    end

    // Mode selection and time-out actions
    // Mode follows the next readback so mode and enable bits agree each cycle
    always_comb begin
        unique case ({en_nxt || level2 || flag_nxt, ie_nxt})
            2'b00: mode_nxt = wdsc_pkg::WDSC_STOPPED;
            2'b01: mode_nxt = wdsc_pkg::WDSC_IRQ;
            2'b10: mode_nxt = wdsc_pkg::WDSC_RESET;
            2'b11: mode_nxt = wdsc_pkg::WDSC_BOTH;
        endcase
        irq_nxt = 1'b0;
        rst_out_nxt = 1'b0;
        if (timeout) begin
            unique case (mode_r)
                wdsc_pkg::WDSC_STOPPED: irq_nxt = 1'b0;
                wdsc_pkg::WDSC_IRQ: irq_nxt = 1'b1;
                wdsc_pkg::WDSC_RESET: rst_out_nxt = 1'b1;
                wdsc_pkg::WDSC_BOTH: irq_nxt = 1'b1;
                default: irq_nxt = 1'b0;
            endcase
        end
        rdata_nxt = 8'h00;
        rdata_nxt[wdsc_pkg::IRQ_EN_BIT] = ie_nxt;
        rdata_nxt[5] = ps_nxt[3];
        rdata_nxt[wdsc_pkg::UNLOCK_BIT] = unlock_nxt;
        rdata_nxt[wdsc_pkg::ENABLE_BIT] = en_nxt || level2 || flag_nxt;
        rdata_nxt[2:0] = ps_nxt[2:0];
    end

    // Register all control state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_r <= 1'b0;
            en_r <= 1'b0;
            ie_r <= 1'b0;
            ps_r <= wdsc_pkg::PRESCALE_RST;
            unlock_r <= 1'b0;
            ucnt_r <= 3'h0;
            irq_r <= 1'b0;
            rst_out_r <= 1'b0;
            rdata_r <= 8'h00;
            mode_r <= wdsc_pkg::WDSC_STOPPED;
        end else begin
            flag_r <= flag_nxt;
            en_r <= en_nxt;
            ie_r <= ie_nxt;
            ps_r <= ps_nxt;
            unlock_r <= unlock_nxt;
            ucnt_r <= ucnt_nxt;
            irq_r <= irq_nxt;
            rst_out_r <= rst_out_nxt;
            rdata_r <= rdata_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ==========================================================
    // Time-out counter
    wdsc_timer #(
        .BASE(BASE_TICKS),
        .CW(32)
    ) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(mode_r != wdsc_pkg::WDSC_STOPPED),
        .kick_in(kick_in),
        .prescale_in(ps_r),
        .timeout_out(timeout)
    );

    assign ctrl_rdata_out = rdata_r;
    assign dog_reset_flag_out = flag_r;
    assign dog_irq_out = irq_r;
    assign dog_reset_out = rst_out_r;
    assign mode_out = mode_r;
endmodule : wdsc_top

/* dv/wdsc_chk.sv */
// Port-level assertions for the watchdog safety control block
`timescale 1ns/1ps
module wdsc_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic safety_level_fuse_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic [7:0] ctrl_rdata_out,
    input wire logic dog_reset_flag_out,
    input wire logic dog_irq_out,
    input wire logic dog_reset_out,
    input wire logic [3:0] mode_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire [7:0] rd = ctrl_rdata_out;
    // ==========================================================
    // Enable, unlock and prescale protection
    a_lvl2_on: assert property (
        !$past(rst_in) && safety_level_fuse_in && $past(safety_level_fuse_in, 3) |-> rd[3])
        else $error("enable low at level two");
    a_locked_en: assert property (
        ctrl_wr_in && !ctrl_wdata_in[3] && !rd[4] && rd[3] |=> rd[3])
        else $error("enable cleared without unlock");
    a_locked_pre: assert property (
        ctrl_wr_in && !rd[4] && rd[3] |=> {rd[5], rd[2:0]} == $past({rd[5], rd[2:0]}))
        else $error("prescale changed while locked");
    a_unlock_drop: assert property ($rose(rd[4]) |-> ##[1:4] !rd[4])
        else $error("unlock did not self clear");
    a_flag_force: assert property (
        dog_reset_flag_out && $past(dog_reset_flag_out) |-> rd[3])
        else $error("enable low with reset flag set");
    // ==========================================================
    // Mode selection and time-out actions
    a_mode_map: assert property (!$past(rst_in) |->
        mode_out == (rd[3] ? (rd[6] ? 4'h8 : 4'h4) : (rd[6] ? 4'h2 : 4'h1)))
        else $error("mode does not match enable bits");
    a_irq_no_rst: assert property (dog_reset_out |-> $past(rd[3], 2))
        else $error("reset action while enable low");
    a_ie_autoclr: assert property (dog_irq_out && rd[3] |-> ##[0:1] !rd[6])
        else $error("irq enable kept after combined interrupt");
    // Main scenarios reached
    c_reset: cover property (dog_reset_out);
    c_both_irq: cover property (dog_irq_out && rd[3]);
    c_disable: cover property ($fell(rd[3]));
endmodule : wdsc_chk

bind wdsc_top wdsc_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .safety_level_fuse_in(safety_level_fuse_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_wdata_in(ctrl_wdata_in), .ctrl_rdata_out(ctrl_rdata_out),
    .dog_reset_flag_out(dog_reset_flag_out), .dog_irq_out(dog_irq_out),
    .dog_reset_out(dog_reset_out), .mode_out(mode_out));

/* dv/test_wdsc_top.sv */
// Self-checking bench for the watchdog safety control block
`timescale 1ns/1ps
module test_wdsc_top;
    logic clk_in = 0, rst_in = 1, fuse = 0, wr = 0, kick = 0, cwr = 0;
    logic [7:0] wd = 8'h00, rd;
    logic flg, irq, rst_o;
    logic [3:0] mode;
    logic [12:0] mq[$], eq[$];
    logic [1:0] vq[$];
    int n_errors = 0, num_checks = 0, cyc = 0, seed = 32'he9dfc439;
    always #2 clk_in = ~clk_in;
    // Small base count keeps every time-out short
    wdsc_top #(.BASE_TICKS(4)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .safety_level_fuse_in(fuse), .ctrl_wr_in(wr), .ctrl_wdata_in(wd), .kick_in(kick),
        .cause_wr_in(cwr), .cause_wdata_in(8'h00), .dog_reset_flag_in(1'b0),
        .ctrl_rdata_out(rd), .dog_reset_flag_out(flg), .dog_irq_out(irq),
        .dog_reset_out(rst_o), .mode_out(mode));
    // ==========================================================
    // Tasks
    task automatic check(string nm, logic [12:0] e, logic [12:0] s);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic rst(logic f);
        fuse = f;
        rst_in = 1;
        repeat (4) @(negedge clk_in);
        rst_in = 0;
    endtask : rst
    // Strobe held high across both writes, never lowered and raised in one step
    task automatic put2(logic [7:0] a, logic [7:0] b, bit two = 1);
        wd = a;
        wr = 1;
        @(negedge clk_in);
        if (two) begin
            wd = b;
            @(negedge clk_in);
        end
        wr = 0;
    endtask : put2
    task automatic exp(logic [12:0] m, logic [12:0] v);
        mq.push_back(m);
        eq.push_back(v);
        @(negedge clk_in);
    endtask : exp
    task automatic ev(logic [1:0] k);
        vq.push_back(k);
        while (vq.size() > 0) @(negedge clk_in);
    endtask : ev
    // ==========================================================
    // Monitors: readback noted by the driver, then events
    always @(negedge clk_in) #1 if (mq.size() > 0) begin
        check("ctrl", eq.pop_front(), {flg, mode, rd} & mq.pop_front());
    end
    // An event with nothing noted is a spurious time-out action
    always @(posedge clk_in) #1 if (irq || rst_o) begin
        if (vq.size() == 0) check("event", 13'h0, {rst_o, irq});
        else check("event", {11'h0, vq.pop_front()}, {rst_o, irq});
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        rst(0);
        exp(13'h1fff, 13'h100);
        put2(8'h21, 8'h00, 0);
        put2(8'h29, 8'h00, 0);
        exp(13'h0fff, 13'h429);
        for (int i = 0; i < 4; i++) begin
            put2(($random(seed) & 8'ha7) | 8'h08, 8'h00, 0);
            exp(13'h027, 13'h021);
        end
        put2(8'h39, 8'h00, 0);
        exp(13'h010, 13'h010);
        repeat (4) @(negedge clk_in);
        exp(13'h010, 13'h000);
        put2(8'h21, 8'h00, 0);
        exp(13'h008, 13'h008);
        put2(8'h39, 8'h05);
        exp(13'h0fff, 13'h105);
        $display("level one enable and unlock done");
        put2(8'h43, 8'h00, 0);
        exp(13'h0fff, 13'h243);
        ev(2'h1);
        put2(8'h4b, 8'h00, 0);
        exp(13'h0fff, 13'h84b);
        ev(2'h1);
        exp(13'h040, 13'h000);
        put2(8'h4b, 8'h00, 0);
        ev(2'h1);
        ev(2'h2);
        kick = 1;
        // Flag follows the reset pulse by one cycle
        @(negedge clk_in);
        exp(13'h1008, 13'h1008);
        put2(8'h1b, 8'h03);
        exp(13'h008, 13'h008);
        cwr = 1;
        @(negedge clk_in);
        cwr = 0;
        put2(8'h1b, 8'h03);
        exp(13'h1fff, 13'h0103);
        $display("time-out actions done");
        rst(1);
        repeat (2) @(negedge clk_in);
        exp(13'h0fff, 13'h408);
        put2(8'h18, 8'h00);
        exp(13'h008, 13'h008);
        put2(8'h18, 8'h0d);
        exp(13'h027, 13'h005);
        put2(8'h0a, 8'h00, 0);
        exp(13'h027, 13'h005);
        kick = 0;
        ev(2'h2);
        $display("level two done");
        stop_test();
    end
endmodule : test_wdsc_top
